// >>> core/crf_regs.sv
/*
  Programmer-visible register state of the CPU core: eight general
  registers with part access, program counter and condition flags.
  Assumes the execution datapath and exception logic drive the ports.
*/
// Summary of operation
// - Eight identical 32-bit general registers
// - Each splits into extended and lower halves
// - Lower half splits into high, low bytes
// - Access width chosen per operation
// - Register seven doubles as stack pointer
// - 24-bit program counter holds next address
// - Fetch address forces bit zero low
// - Reset sequence loads program counter vector
// - Reset sets mask bit and clears the others
// - Mask blocks interrupts except non-maskable
// - Every exception sequence sets mask bit
// - Bits six and four are user bits
// - Byte half-carry from bit three
// - Word half-carry from bit eleven
// - Long half-carry from bit twenty-seven
// - Negative flag takes result sign bit
// - Flags load, store, and, or, xor
// - Branch logic sees N, Z, V, C
// - Zero flag set on zero result
// - Overflow flag follows arithmetic overflow
// - Carry flag: carry, borrow, shifted bit
`timescale 1ns/10ps
module crf_regs
  import crf_pkg::*;
(
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         nrst,
  // General register write
  input  wire logic         gpr_wr_en,
  input  crf_sel_t          gpr_wr_sel,
  input  wire logic [31:0]  gpr_wr_data,
  // General register read
  input  crf_sel_t          gpr_rd_sel,
  output logic [31:0]       gpr_rd_data,
  output logic [31:0]       stack_holding_gpr,
  // Program counter
  input  wire logic         pc_load,
  input  wire logic [23:0]  pc_load_val,
  input  wire logic         vector_load,
  input  wire logic [23:0]  vector_val,
  output logic [23:0]       pc,
  output logic [23:0]       fetch_addr,
  // Exceptions and interrupts
  input  wire logic         exc_start,
  input  wire logic         irq_req,
  input  wire logic         nmi_req,
  output logic              irq_accept,
  output logic              nmi_accept,
  // Condition flags
  input  crf_flag_op_t      flag_op,
  input  wire logic [7:0]   flag_imm,
  input  crf_alu_t          alu,
  output logic [7:0]        condition_flags,
  output logic [3:0]        branch_flags
);

  // ==========================================================
  // General registers
  logic [31:0] wr_mask;
  logic [31:0] wr_data;
  logic [31:0] rd_word;
  crf_sel_t    rd_sel_q;

  function automatic logic [31:0] part_mask(crf_sel_t s);
    logic [31:0] m;
    m = 32'h00000000;
    unique case (s.size)
      SZ_LONG: m = 32'hffffffff;
      SZ_EXT:  m = 32'hffff0000;
      SZ_LOW:  m = 32'h0000ffff;
      SZ_BYTE: m = s.hi_byte ? 32'h0000ff00 : 32'h000000ff;
      default: m = 32'h00000000;
    endcase
    return m;
  endfunction : part_mask

  // Write data aligned to the selected part
  always_comb begin
    wr_mask = part_mask(gpr_wr_sel);
    unique case (gpr_wr_sel.size)
      SZ_EXT:  wr_data = {gpr_wr_data[15:0], 16'h0000};
      SZ_BYTE: wr_data = {16'h0000, gpr_wr_data[7:0],
                          gpr_wr_data[7:0]};
      default: wr_data = gpr_wr_data;
    endcase
  end

  crf_gpr_bank #(
    .COUNT (GPR_COUNT)
  ) u_bank (
    .clk        (clk),
    .nrst       (nrst),
    .wr_en      (gpr_wr_en),
    .wr_idx     (gpr_wr_sel.idx),
    .wr_mask    (wr_mask),
    .wr_data    (wr_data),
    .rd_idx     (gpr_rd_sel.idx),
    .rd_word    (rd_word),
    .stack_word (stack_holding_gpr)
  );

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst)
      rd_sel_q <= '{idx: 3'h0, size: SZ_LONG, hi_byte: 1'b0};
    else
      rd_sel_q <= gpr_rd_sel;
  end

  // Read part right-aligned
  always_comb begin
    unique case (rd_sel_q.size)
      SZ_EXT:  gpr_rd_data = {16'h0000, rd_word[31:16]};
      SZ_LOW:  gpr_rd_data = {16'h0000, rd_word[15:0]};
      SZ_BYTE: gpr_rd_data = rd_sel_q.hi_byte ?
                 {24'h000000, rd_word[15:8]} :
                 {24'h000000, rd_word[7:0]};
      default: gpr_rd_data = rd_word;
    endcase
  end

  // ==========================================================
  // Program counter
  logic [23:0] next_pc;

  always_comb begin
    next_pc = pc;
    if (vector_load)
      next_pc = vector_val;
    else if (pc_load)
      next_pc = pc_load_val;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst)
      pc <= PC_RESET;
    else
      pc <= next_pc;
  end

  assign fetch_addr = {pc[23:1], 1'b0};

  // ==========================================================
  // Condition flags
  logic [7:0] next_flags;
  logic       h_f;
  logic       n_f;
  logic       z_f;
  logic       v_f;
  logic       c_f;

  crf_flag_calc u_calc (
    .alu        (alu),
    .half_flag  (h_f),
    .neg_flag   (n_f),
    .zero_flag  (z_f),
    .ovf_flag   (v_f),
    .carry_flag (c_f)
  );

  always_comb begin
    next_flags = condition_flags;
    unique case (flag_op)
      FO_NONE:  next_flags = condition_flags;
      FO_ARITH: begin
        next_flags[FLAG_HALF_POS]  = h_f;
        next_flags[FLAG_NEG_POS]   = n_f;
        next_flags[FLAG_ZERO_POS]  = z_f;
        next_flags[FLAG_OVF_POS]   = v_f;
        next_flags[FLAG_CARRY_POS] = c_f;
      end
      FO_LOGIC: begin
        next_flags[FLAG_NEG_POS]  = n_f;
        next_flags[FLAG_ZERO_POS] = z_f;
        next_flags[FLAG_OVF_POS]  = 1'b0;
      end
      FO_LOAD:  next_flags = flag_imm;
      FO_AND:   next_flags = condition_flags & flag_imm;
      FO_OR:    next_flags = condition_flags | flag_imm;
      FO_XOR:   next_flags = condition_flags ^ flag_imm;
      default:  next_flags = condition_flags;
    endcase
    if (exc_start)
      next_flags[FLAG_MASK_POS] = 1'b1;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst)
      condition_flags <= FLAGS_RESET;
    else
      condition_flags <= next_flags;
  end

  assign branch_flags = condition_flags[3:0];
  assign irq_accept = irq_req && !condition_flags[FLAG_MASK_POS];
  assign nmi_accept = nmi_req;

  // ==========================================================
  // Checks
  property p_reset_mask;
    @(posedge clk) $rose(nrst) |-> condition_flags[FLAG_MASK_POS];
  endproperty
  a_reset_mask: assert property (p_reset_mask)
    else $error("Mask bit not set after reset");

  property p_exc_mask;
    @(posedge clk) disable iff (!nrst)
      exc_start |=> condition_flags[FLAG_MASK_POS];
  endproperty
  a_exc_mask: assert property (p_exc_mask)
    else $error("Mask bit not set by exception");

  property p_irq_block;
    @(posedge clk) disable iff (!nrst)
      condition_flags[FLAG_MASK_POS] |-> !irq_accept;
  endproperty
  a_irq_block: assert property (p_irq_block)
    else $error("Interrupt accepted while masked");

  property p_nmi;
    @(posedge clk) disable iff (!nrst) nmi_req |-> nmi_accept;
  endproperty
  a_nmi: assert property (p_nmi)
    else $error("Non-maskable request refused");

  property p_fetch_even;
    @(posedge clk) disable iff (!nrst)
      !fetch_addr[0] && fetch_addr[23:1] == pc[23:1];
  endproperty
  a_fetch_even: assert property (p_fetch_even)
    else $error("Fetch address bit zero not forced");

  property p_vector;
    @(posedge clk) disable iff (!nrst)
      vector_load |=> pc == $past(vector_val);
  endproperty
  a_vector: assert property (p_vector)
    else $error("Vector not loaded into counter");

  property p_pc_hold;
    @(posedge clk) disable iff (!nrst)
      !vector_load && !pc_load |=> $stable(pc);
  endproperty
  a_pc_hold: assert property (p_pc_hold)
    else $error("Counter changed without load");

  property p_and_op;
    @(posedge clk) disable iff (!nrst)
      flag_op == FO_AND && !exc_start |=>
        condition_flags == ($past(condition_flags) & $past(flag_imm));
  endproperty
  a_and_op: assert property (p_and_op)
    else $error("Flag AND result wrong");

  property p_byte_write;
    @(posedge clk) disable iff (!nrst)
      gpr_wr_en && gpr_wr_sel.size == SZ_BYTE && !gpr_wr_sel.hi_byte
      && gpr_rd_sel.idx == gpr_wr_sel.idx |=>
        rd_word[31:8] == $past(u_bank.mem[gpr_wr_sel.idx][31:8]);
  endproperty
  a_byte_write: assert property (p_byte_write)
    else $error("Byte write disturbed other bits");

  property p_branch;
    @(posedge clk) disable iff (!nrst)
      branch_flags == condition_flags[FLAG_NEG_POS:FLAG_CARRY_POS];
  endproperty
  a_branch: assert property (p_branch)
    else $error("Branch flags differ from register");

  property p_load_op;
    @(posedge clk) disable iff (!nrst)
      flag_op == FO_LOAD && !exc_start |=>
        condition_flags == $past(flag_imm);
  endproperty
  a_load_op: assert property (p_load_op)
    else $error("Flag load result wrong");

  property p_user_keep;
    @(posedge clk) disable iff (!nrst)
      flag_op == FO_ARITH || flag_op == FO_LOGIC |=>
        $stable(condition_flags[FLAG_SPARE6]) &&
        $stable(condition_flags[FLAG_SPARE4]);
  endproperty
  a_user_keep: assert property (p_user_keep)
    else $error("User bit changed by arithmetic");

  property p_half_byte;
    @(posedge clk) disable iff (!nrst)
      flag_op == FO_ARITH && alu.size == SZ_BYTE |=>
        condition_flags[FLAG_HALF_POS] ==
        $past(alu.carry_vec[HC_BYTE_BIT]);
  endproperty
  a_half_byte: assert property (p_half_byte)
    else $error("Byte half-carry wrong");

  property p_half_word;
    @(posedge clk) disable iff (!nrst)
      flag_op == FO_ARITH && alu.size == SZ_LOW |=>
        condition_flags[FLAG_HALF_POS] ==
        $past(alu.carry_vec[HC_WORD_BIT]);
  endproperty
  a_half_word: assert property (p_half_word)
    else $error("Word half-carry wrong");

  property p_logic_ovf;
    @(posedge clk) disable iff (!nrst)
      flag_op == FO_LOGIC |=> !condition_flags[FLAG_OVF_POS];
  endproperty
  a_logic_ovf: assert property (p_logic_ovf)
    else $error("Overflow flag set by logic result");

endmodule : crf_regs

// >>> pkg/crf_pkg.sv
/*
  Package for the CPU register file and condition flags.
  Assumes a single clock domain and the execution datapath outside.
*/
package crf_pkg;

  // ==========================================================
  // Widths and positions
  localparam int GPR_COUNT     = 8;
  localparam int GPR_WIDTH     = 32;
  localparam int PC_WIDTH      = 24;
  localparam int FLAGS_WIDTH   = 8;
  localparam logic [2:0] STACK_GPR_IDX = 3'h7;

  localparam int FLAG_MASK_POS  = 7;
  localparam int FLAG_SPARE6    = 6;
  localparam int FLAG_HALF_POS  = 5;
  localparam int FLAG_SPARE4    = 4;
  localparam int FLAG_NEG_POS   = 3;
  localparam int FLAG_ZERO_POS  = 2;
  localparam int FLAG_OVF_POS   = 1;
  localparam int FLAG_CARRY_POS = 0;

  // Half-carry bit positions per size
  localparam int HC_BYTE_BIT = 3;
  localparam int HC_WORD_BIT = 11;
  localparam int HC_LONG_BIT = 27;

  // ==========================================================
  // Reset values (only the mask bit is set)
  localparam logic [7:0]  FLAGS_RESET = 8'h80;
  localparam logic [23:0] PC_RESET    = 24'h000000;
  localparam logic [31:0] GPR_RESET   = 32'h00000000;

  // ==========================================================
  // Access sizes, selected per operation
  typedef enum logic [3:0] {
    SZ_LONG  = 4'h1,
    SZ_EXT   = 4'h2,
    SZ_LOW   = 4'h4,
    SZ_BYTE  = 4'h8
  } crf_size_t;

  // Flag operations
  typedef enum logic [6:0] {
    FO_NONE  = 7'h01,
    FO_ARITH = 7'h02,
    FO_LOGIC = 7'h04,
    FO_LOAD  = 7'h08,
    FO_AND   = 7'h10,
    FO_OR    = 7'h20,
    FO_XOR   = 7'h40
  } crf_flag_op_t;

  // Register port: index, size, byte half (for SZ_BYTE, 1 = high)
  typedef struct packed {
    logic [2:0] idx;
    crf_size_t  size;
    logic       hi_byte;
  } crf_sel_t;

  // Arithmetic result from the datapath
  typedef struct packed {
    logic [31:0] result;
    crf_size_t   size;
    logic        overflow;
    logic        carry;
    logic [31:0] carry_vec;
  } crf_alu_t;

endpackage : crf_pkg

// >>> core/crf_gpr_bank.sv
/*
  Bank of eight 32-bit general registers with part writes.
  Assumes a synchronous write port; read is registered.
*/
`timescale 1ns/10ps
module crf_gpr_bank
  import crf_pkg::*;
#(
  parameter int COUNT = GPR_COUNT
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // Write port
  input  wire logic        wr_en,
  input  wire logic [2:0]  wr_idx,
  input  wire logic [31:0] wr_mask,
  input  wire logic [31:0] wr_data,
  // Read port
  input  wire logic [2:0]  rd_idx,
  output logic [31:0]      rd_word,
  // Stack holding register
  output logic [31:0]      stack_word
);

  logic [31:0] mem [COUNT];
  logic [31:0] next_mem [COUNT];
  logic [31:0] next_rd_word;

  // ==========================================================
  // Masked update
  always_comb begin
    for (int i = 0; i < COUNT; i++) begin
      next_mem[i] = mem[i];
      if (wr_en && wr_idx == 3'(i))
        next_mem[i] = (mem[i] & ~wr_mask) | (wr_data & wr_mask);
    end
    next_rd_word = next_mem[rd_idx];
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < COUNT; i++)
        mem[i] <= GPR_RESET;
      rd_word <= GPR_RESET;
    end else begin
      for (int i = 0; i < COUNT; i++)
        mem[i] <= next_mem[i];
      rd_word <= next_rd_word;
    end
  end

  assign stack_word = mem[STACK_GPR_IDX];

endmodule : crf_gpr_bank

// >>> core/crf_flag_calc.sv
/*
  Arithmetic flag computation from a datapath result.
  Assumes the datapath supplies per-bit carries of the operation.
*/
`timescale 1ns/10ps
module crf_flag_calc
  import crf_pkg::*;
(
  // Arithmetic result
  input  crf_alu_t   alu,
  // Flags out
  output logic       half_flag,
  output logic       neg_flag,
  output logic       zero_flag,
  output logic       ovf_flag,
  output logic       carry_flag
);

  always_comb begin
    half_flag  = 1'b0;
    neg_flag   = 1'b0;
    zero_flag  = 1'b0;
    unique case (alu.size)
      SZ_LONG, SZ_EXT: begin
        half_flag = alu.carry_vec[HC_LONG_BIT];
        neg_flag  = alu.result[31];
        zero_flag = (alu.result == 32'h00000000);
      end
      SZ_LOW: begin
        half_flag = alu.carry_vec[HC_WORD_BIT];
        neg_flag  = alu.result[15];
        zero_flag = (alu.result[15:0] == 16'h0000);
      end
      SZ_BYTE: begin
        half_flag = alu.carry_vec[HC_BYTE_BIT];
        neg_flag  = alu.result[7];
        zero_flag = (alu.result[7:0] == 8'h00);
      end
      default: ;
    endcase
    ovf_flag   = alu.overflow;
    carry_flag = alu.carry;
  end

endmodule : crf_flag_calc

// >>> bench/crf_dp_model.sv
/*
  Datapath stand-in: add or subtract with per-bit carries.
  Assumes operands right-aligned to the chosen size.
*/
`timescale 1ns/10ps
module crf_dp_model
  import crf_pkg::*;
(
  // Operands
  input  wire logic [31:0] a,
  input  wire logic [31:0] b,
  input  wire logic        sub,
  input  crf_size_t        size,
  // Result
  output crf_alu_t         alu
);
  // ==========================================================
  // Result, carries, overflow
  always_comb begin
    int     w;
    longint m;
    longint r;
    w = (size == SZ_BYTE) ? 8 : (size == SZ_LONG) ? 32 : 16;
    m = 0;
    r = 0;
    alu = '0;
    alu.size = size;
    for (int i = 0; i < 32; i++) begin
      m = (64'h1 << (i + 1)) - 1;
      r = sub ? (a & m) - (b & m) : (a & m) + (b & m);
      alu.carry_vec[i] = r[i + 1];
    end
    m = (64'h1 << w) - 1;
    r = sub ? a - b : a + b;
    alu.result = 32'(r & m);
    alu.carry = alu.carry_vec[w - 1];
    alu.overflow = (sub ? (a[w - 1] != b[w - 1]) : (a[w - 1] == b[w - 1]))
                   && (alu.result[w - 1] != a[w - 1]);
  end
endmodule : crf_dp_model

// >>> bench/tb_cpu_register_file_flags.sv
/*
  Bench for crf_regs: random part writes, counter loads, flag ops.
  Assumes crf_dp_model supplies the arithmetic result.
*/
`timescale 1ns/10ps
module tb_cpu_register_file_flags
  import crf_pkg::*;
;
  // ==========================================================
  // Signals and model state
  logic         clk, nrst, gpr_wr_en, pc_load, vector_load;
  logic         exc_start, irq_req, nmi_req, irq_acc, nmi_acc, sub;
  crf_sel_t     wsel, rsel;
  logic [31:0]  wdata, rd_data, stk, a, b, lf, ex;
  logic [23:0]  pcv, vecv, pc, faddr, e;
  crf_flag_op_t fop;
  crf_size_t    asz;
  crf_alu_t     alu;
  logic [7:0]   fimm, flags, m_fl;
  logic [3:0]   bfl;
  logic [31:0]  m_gpr [8];
  int           err_total, n_tests;
  localparam crf_size_t SZS [4] = '{SZ_LONG, SZ_EXT, SZ_LOW, SZ_BYTE};
  localparam crf_flag_op_t OPS [7] = '{FO_NONE, FO_ARITH, FO_LOGIC,
                                       FO_LOAD, FO_AND, FO_OR, FO_XOR};

  // ==========================================================
  // Instances
  crf_regs uut (.clk(clk), .nrst(nrst), .gpr_wr_en(gpr_wr_en),
    .gpr_wr_sel(wsel), .gpr_wr_data(wdata), .gpr_rd_sel(rsel),
    .gpr_rd_data(rd_data), .stack_holding_gpr(stk), .pc_load(pc_load),
    .pc_load_val(pcv), .vector_load(vector_load), .vector_val(vecv),
    .pc(pc), .fetch_addr(faddr), .exc_start(exc_start),
    .irq_req(irq_req), .nmi_req(nmi_req), .irq_accept(irq_acc),
    .nmi_accept(nmi_acc), .flag_op(fop), .flag_imm(fimm), .alu(alu),
    .condition_flags(flags), .branch_flags(bfl));
  crf_dp_model dp (.a(a), .b(b), .sub(sub), .size(asz), .alu(alu));

  // ==========================================================
  // Helpers
  function automatic logic [31:0] nx(logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : nx

  function automatic logic [31:0] part(logic [31:0] w, crf_sel_t s);
    case (s.size)
      SZ_EXT:  return {16'h0, w[31:16]};
      SZ_LOW:  return {16'h0, w[15:0]};
      SZ_BYTE: return s.hi_byte ? {24'h0, w[15:8]} : {24'h0, w[7:0]};
      default: return w;
    endcase
  endfunction : part

  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic tick();
    @(posedge clk);
    #1;
  endtask : tick

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report

  // Flag operation for one cycle, model updated from the operands
  task automatic fl_op(crf_flag_op_t op, logic [7:0] imm, logic exc);
    int     w;
    int     hb;
    longint mk;
    longint r;
    longint hr;
    w = (asz == SZ_BYTE) ? 8 : (asz == SZ_LONG) ? 32 : 16;
    hb = (w == 8) ? 4 : (w == 16) ? 12 : 28;
    mk = (64'h1 << hb) - 1;
    hr = sub ? (a & mk) - (b & mk) : (a & mk) + (b & mk);
    mk = (64'h1 << w) - 1;
    r = sub ? (a & mk) - (b & mk) : (a & mk) + (b & mk);
    case (op)
      FO_LOAD: m_fl = imm;
      FO_AND:  m_fl = m_fl & imm;
      FO_OR:   m_fl = m_fl | imm;
      FO_XOR:  m_fl = m_fl ^ imm;
      FO_ARITH, FO_LOGIC: begin
        m_fl[3] = r[w - 1];
        m_fl[2] = ((r & mk) == 0);
        m_fl[1] = (op == FO_ARITH) && (r[w - 1] != a[w - 1]) &&
                  (sub ? (a[w - 1] != b[w - 1]) : (a[w - 1] == b[w - 1]));
        if (op == FO_ARITH) begin
          m_fl[5] = hr[hb];
          m_fl[0] = r[w];
        end
      end
      default: m_fl = m_fl;
    endcase
    if (exc) m_fl[7] = 1'b1;
    fop = op;
    fimm = imm;
    exc_start = exc;
    tick();
    fop = FO_NONE;
    exc_start = 1'b0;
    chk("hflag", flags[5], m_fl[5]);
    chk("flags", flags, m_fl);
    chk("branch", bfl, m_fl[3:0]);
    chk("irq", irq_acc, irq_req & ~m_fl[7]);
    chk("nmi", nmi_acc, nmi_req);
  endtask : fl_op

  // ==========================================================
  // Clock and watchdog
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    #900000;
    err_total++;
    final_report();
  end

  // ==========================================================
  // Main sequence
  initial begin
    {nrst, gpr_wr_en, pc_load, vector_load, exc_start} = '0;
    {irq_req, nmi_req, sub, a, b, wdata, pcv, vecv, fimm} = '0;
    wsel = '{3'h0, SZ_LONG, 1'b0};
    rsel = wsel;
    fop = FO_NONE;
    asz = SZ_BYTE;
    lf = 32'hd251;
    err_total = 0;
    n_tests = 0;
    m_fl = 8'h80;
    for (int i = 0; i < 8; i++) m_gpr[i] = 32'h0;
    repeat (20) @(posedge clk);
    #1 nrst = 1'b1;
    chk("flags_rst", flags, 8'h80);
    for (int k = 0; k < 48; k++) begin
      lf = nx(lf);
      wsel = '{lf[2:0], SZS[lf[5:4]], lf[6]};
      rsel = '{lf[2:0], SZS[lf[9:8]], lf[10]};
      wdata = nx(lf);
      case (wsel.size)
        SZ_EXT:  m_gpr[wsel.idx][31:16] = wdata[15:0];
        SZ_LOW:  m_gpr[wsel.idx][15:0] = wdata[15:0];
        SZ_BYTE: begin
          if (wsel.hi_byte) m_gpr[wsel.idx][15:8] = wdata[7:0];
          else m_gpr[wsel.idx][7:0] = wdata[7:0];
        end
        default: m_gpr[wsel.idx] = wdata;
      endcase
      gpr_wr_en = 1'b1;
      tick();
      gpr_wr_en = 1'b0;
      tick();
      ex = part(m_gpr[rsel.idx], rsel);
      chk("rd_data", rd_data, ex);
      chk("stack", stk, m_gpr[7]);
    end
    for (int k = 0; k < 8; k++) begin
      lf = nx(lf);
      pcv = lf[23:0];
      vecv = ~lf[23:0];
      pc_load = 1'b1;
      vector_load = k[0];
      e = k[0] ? vecv : pcv;
      tick();
      {pc_load, vector_load} = '0;
      chk("pc", pc, e);
      chk("fetch", faddr, {e[23:1], 1'b0});
    end
    for (int k = 0; k < 64; k++) begin
      lf = nx(lf);
      a = lf;
      lf = nx(lf);
      b = lf;
      sub = lf[0];
      irq_req = lf[1];
      nmi_req = lf[2];
      asz = SZS[lf[5:4]];
      if (asz == SZ_EXT) asz = SZ_LOW;
      fl_op(OPS[lf[12:8] % 7], lf[23:16], lf[24] & lf[25]);
    end
    // Reset again in mid-run with the mask clear
    fl_op(FO_LOAD, 8'h00, 1'b0);
    nrst = 1'b0;
    tick();
    nrst = 1'b1;
    m_fl = 8'h80;
    chk("flags_rst", flags, m_fl);
    fl_op(FO_NONE, 8'h00, 1'b0);
    final_report();
  end
endmodule : tb_cpu_register_file_flags
